// ### verilog/speed_limit_ramp_select.sv
// Speed setpoint shaping: forward limit and direction-aware ramps
`timescale 1ns/1ns
module speed_limit_ramp_select #(
  parameter int STEP_CYCLES = speed_shape_pkg::STEP_CYCLES
) (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  resetn_in,
  // Ramp times, 100 ms units
  input  wire speed_shape_pkg::ramp_t fwd_accel_fast_in,
  input  wire speed_shape_pkg::ramp_t fwd_accel_slow_in,
  input  wire speed_shape_pkg::ramp_t fwd_decel_fast_in,
  input  wire speed_shape_pkg::ramp_t fwd_decel_slow_in,
  input  wire speed_shape_pkg::ramp_t rev_accel_fast_in,
  input  wire speed_shape_pkg::ramp_t rev_accel_slow_in,
  input  wire speed_shape_pkg::ramp_t rev_decel_fast_in,
  input  wire speed_shape_pkg::ramp_t rev_decel_slow_in,
  // Forward speed limits, percent
  input  wire speed_shape_pkg::pct_t  max_fwd_fast_in,
  input  wire speed_shape_pkg::pct_t  max_fwd_slow_in,
  input  wire speed_shape_pkg::pct_t  min_fwd_fast_in,
  input  wire speed_shape_pkg::pct_t  min_fwd_slow_in,
  // Operator switches and potentiometer
  input  wire logic                  selector_present_in,
  input  wire logic                  selector_fast_in,
  input  wire logic                  pot_enable_in,
  input  wire logic                  pot_valid_in,
  input  wire speed_shape_pkg::pot_t  pot_position_in,
  // Throttle demand
  input  wire logic                  demand_rev_in,
  input  wire speed_shape_pkg::pct_t  demand_pct_in,
  // Drive setpoint and status
  output logic                       speed_rev_out,
  output speed_shape_pkg::pct_t      speed_pct_out,
  output speed_shape_pkg::pct_t      limit_pct_out,
  output logic                       fast_sel_out,
  output logic                       at_target_out
);
  import speed_shape_pkg::*;

  // Divider width covers step periods up to 65536 clocks
  localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

  speed_limit_if lim ();

  // ***************************************************************
  // Limit selection
  // ***************************************************************
  speed_limit_select u_limit (
    .clk_in              (clk_in),
    .resetn_in           (resetn_in),
    .max_fast_in         (max_fwd_fast_in),
    .max_slow_in         (max_fwd_slow_in),
    .min_fast_in         (min_fwd_fast_in),
    .min_slow_in         (min_fwd_slow_in),
    .selector_present_in (selector_present_in),
    .selector_fast_in    (selector_fast_in),
    .pot_enable_in       (pot_enable_in),
    .pot_valid_in        (pot_valid_in),
    .pot_position_in     (pot_position_in),
    .lim                 (lim)
  );

  // ***************************************************************
  // Target and ramp time selection
  // ***************************************************************
  pct_t        target_pct;
  ramp_t       ramp_time;
  ramp_state_t state_next;
  logic        dir_change;
  logic        rev_reg;
  pct_t        pct_reg;
  ramp_state_t state_reg;
  logic [15:0] div_reg;
  ramp_t       step_reg;
  logic        tick;
  logic        step_due;
  logic        flip_now;

  function automatic pct_t cap_pct(input pct_t v, input pct_t top);
    cap_pct = (v > top) ? top : v;
  endfunction

  function automatic ramp_t pick_time(input logic fast, input ramp_t f, input ramp_t s);
    pick_time = fast ? f : s;
  endfunction

  // Reverse limits live elsewhere; reverse is only held to full scale here
  assign target_pct = demand_rev_in ? cap_pct(demand_pct_in, FULL_PCT)
                                    : cap_pct(demand_pct_in, lim.limit_pct);

  // ***************************************************************
  // Direction handling
  // ***************************************************************
  // Opposite demand must first brake the current direction to standstill
  assign dir_change = (demand_rev_in != rev_reg) && (pct_reg != ZERO_PCT);
  // At standstill the new direction is taken first, so no step lands
  // in the cycle in which the direction turns
  assign flip_now   = (demand_rev_in != rev_reg) && (pct_reg == ZERO_PCT);

  always_comb begin
    if (dir_change || target_pct < pct_reg) begin
      state_next = RAMP_DOWN;
    end else if (target_pct > pct_reg) begin
      state_next = RAMP_UP;
    end else begin
      state_next = RAMP_HOLD;
    end
  end

  always_comb begin
    // Hold needs no time; its step count stays parked at zero
    ramp_time = RAMP_ZERO;
    unique case (state_reg)
      RAMP_UP:   ramp_time = rev_reg
                   ? pick_time(lim.fast_sel, rev_accel_fast_in, rev_accel_slow_in)
                   : pick_time(lim.fast_sel, fwd_accel_fast_in, fwd_accel_slow_in);
      RAMP_DOWN: ramp_time = rev_reg
                   ? pick_time(lim.fast_sel, rev_decel_fast_in, rev_decel_slow_in)
                   : pick_time(lim.fast_sel, fwd_decel_fast_in, fwd_decel_slow_in);
      RAMP_HOLD: ramp_time = RAMP_ZERO;
    endcase
  end

  // ***************************************************************
  // One percent step timer
  // ***************************************************************
  // Free-running divider: the first step of a ramp may come up to one tick early
  assign tick     = (div_reg == STEP_LAST);
  // A ramp time of T moves one percent every T+1 step periods
  assign step_due = tick && (step_reg >= ramp_time);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
    end
  end

  // Restart the step count on a change of ramp kind so times do not blend
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      step_reg <= RAMP_ZERO;
    end else if (state_next != state_reg || step_due) begin
      step_reg <= RAMP_ZERO;
    end else if (tick && state_reg != RAMP_HOLD) begin
      step_reg <= step_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= RAMP_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // ***************************************************************
  // Speed setpoint
  // ***************************************************************
  // Direction only turns at standstill
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rev_reg <= 1'b0;
    end else if (flip_now) begin
      rev_reg <= demand_rev_in;
    end
  end

  // A step waits while the direction turns
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pct_reg <= ZERO_PCT;
    end else if (step_due && state_next == state_reg && !flip_now) begin
      unique case (state_reg)
        RAMP_UP:   pct_reg <= pct_reg + 7'h01;
        RAMP_DOWN: pct_reg <= pct_reg - 7'h01;
        RAMP_HOLD: pct_reg <= pct_reg;
      endcase
    end
  end

  // ***************************************************************
  // Output registers
  // ***************************************************************
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      speed_rev_out <= 1'b0;
      speed_pct_out <= ZERO_PCT;
    end else begin
      speed_rev_out <= rev_reg;
      speed_pct_out <= pct_reg;
    end
  end

  // Limit and fast-select status follow the limit pipe one flop later; at_target_out comes from the ramp state
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      limit_pct_out <= ZERO_PCT;
      fast_sel_out  <= 1'b1;
      at_target_out <= 1'b1;
    end else begin
      limit_pct_out <= lim.limit_pct;
      fast_sel_out  <= lim.fast_sel;
      // Held low while the direction turns so it never leads speed_rev_out
      at_target_out <= (state_next == RAMP_HOLD) && !flip_now;
    end
  end

endmodule

// ### verilog/speed_shape_pkg.sv
// Constants and types shared by the speed limit and ramp logic
package speed_shape_pkg;

  // ***************************************************************
  // Widths
  // ***************************************************************
  localparam int PCT_W  = 7;
  localparam int RAMP_W = 8;
  localparam int POT_W  = 8;

  typedef logic [PCT_W-1:0]  pct_t;
  typedef logic [RAMP_W-1:0] ramp_t;
  typedef logic [POT_W-1:0]  pot_t;

  // ***************************************************************
  // Scale and reset values
  // ***************************************************************
  localparam pct_t FULL_PCT  = 7'h64;
  localparam pct_t ZERO_PCT  = 7'h00;
  localparam ramp_t RAMP_ZERO = 8'h00;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int RAMP_UNIT_MS  = 100;
  // A ramp unit spans one full scale sweep of 100 one-percent steps
  localparam int STEP_TIME_US  = RAMP_UNIT_MS * 1000 / 100;
  localparam int STEP_CYCLES   = STEP_TIME_US * 1000 / CLK_PERIOD_NS;

  // ***************************************************************
  // Ramp state machine
  // ***************************************************************
  typedef enum logic [2:0] {
    RAMP_HOLD  = 3'b001,
    RAMP_UP    = 3'b010,
    RAMP_DOWN  = 3'b100
  } ramp_state_t;

endpackage

// ### verilog/speed_limit_if.sv
// Carrier between the limit selector and the ramp top
`timescale 1ns/1ns
interface speed_limit_if;
  import speed_shape_pkg::*;

  logic fast_sel;
  pct_t limit_pct;

  modport selector (output fast_sel, output limit_pct);
  modport user     (input  fast_sel, input  limit_pct);
endinterface

// ### verilog/speed_limit_select.sv
// Forward speed limit selection: max, min and potentiometer blend
`timescale 1ns/1ns
module speed_limit_select (
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  // Settings
  input  wire speed_shape_pkg::pct_t max_fast_in,
  input  wire speed_shape_pkg::pct_t max_slow_in,
  input  wire speed_shape_pkg::pct_t min_fast_in,
  input  wire speed_shape_pkg::pct_t min_slow_in,
  // Switches and potentiometer
  input  wire logic                 selector_present_in,
  input  wire logic                 selector_fast_in,
  input  wire logic                 pot_enable_in,
  input  wire logic                 pot_valid_in,
  input  wire speed_shape_pkg::pot_t pot_position_in,
  // Result
  speed_limit_if.selector           lim
);
  import speed_shape_pkg::*;

  typedef logic [PCT_W+POT_W:0] prod_t;

  logic  fast_sel;
  pct_t  max_pct;
  pct_t  min_pct;
  pct_t  limit_next;
  prod_t span_prod;

  function automatic pct_t clamp_pct(input pct_t v, input pct_t top);
    clamp_pct = (v > top) ? top : v;
  endfunction

  // No selector fitted means the fast set alone applies
  assign fast_sel = !selector_present_in || selector_fast_in;
  assign max_pct  = clamp_pct(fast_sel ? max_fast_in : max_slow_in, FULL_PCT);
  // Minimum never above the matching maximum
  assign min_pct  = clamp_pct(fast_sel ? min_fast_in : min_slow_in, max_pct);

  // Positions 128 to 255 get one added, so 255 acts as 256 and the fast end reaches the max exactly
  assign span_prod = prod_t'(max_pct - min_pct) *
                     (prod_t'(pot_position_in) + prod_t'(pot_position_in[POT_W-1]));

  always_comb begin
    if (!pot_enable_in) begin
      limit_next = max_pct;
    end else if (!pot_valid_in) begin
      limit_next = min_pct;
    end else begin
      // Position 0 is the slow end and yields the minimum
      limit_next = min_pct + span_prod[PCT_W+POT_W-1:POT_W];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lim.limit_pct <= ZERO_PCT;
      lim.fast_sel  <= 1'b1;
    end else begin
      lim.limit_pct <= limit_next;
      lim.fast_sel  <= fast_sel;
    end
  end

endmodule

// ### sim/speed_shape_asserts.sv
// Port checker for the speed shaping top
`timescale 1ns/1ns
module speed_shape_asserts #(
  parameter int STEP_CYCLES = 4
) (
  // Clock and reset
  input wire logic                  clk_in,
  input wire logic                  resetn_in,
  // Switches and demand
  input wire logic                  selector_present_in,
  input wire logic                  selector_fast_in,
  input wire logic                  demand_rev_in,
  // Setpoint and status
  input wire logic                  speed_rev_out,
  input wire speed_shape_pkg::pct_t speed_pct_out,
  input wire speed_shape_pkg::pct_t limit_pct_out,
  input wire logic                  fast_sel_out,
  input wire logic                  at_target_out
);
  import speed_shape_pkg::*;
  logic [1:0] settle_reg;
  logic       sel1_reg;
  logic       sel2_reg;
  // Settle count hides the select pipe filled during reset
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      settle_reg <= 2'h0;
      sel1_reg   <= 1'b1;
      sel2_reg   <= 1'b1;
    end else begin
      if (settle_reg != 2'h3) settle_reg <= settle_reg + 2'h1;
      sel1_reg <= !selector_present_in || selector_fast_in;
      sel2_reg <= sel1_reg;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  AST_STEP: assert property ((speed_pct_out - $past(speed_pct_out) + 7'h1) <= 7'h2)
    else $error("setpoint moved more than one step");
  AST_GAP: assert property (STEP_CYCLES >= 4 && $changed(speed_pct_out) |=>
    $stable(speed_pct_out)[*3]) else $error("setpoint steps too close");
  AST_FLIP: assert property ($changed(speed_rev_out) |-> speed_pct_out == ZERO_PCT)
    else $error("direction flipped while moving");
  AST_DIR: assert property ($stable(demand_rev_in)[*2] ##0 at_target_out |->
    speed_rev_out == demand_rev_in) else $error("at target in wrong direction");
  AST_HOLD: assert property (at_target_out && $past(at_target_out) |->
    $stable(speed_pct_out)) else $error("setpoint moved at target");
  AST_LIM: assert property (limit_pct_out <= FULL_PCT)
    else $error("limit above full scale");
  AST_SEL: assert property (settle_reg == 2'h3 |-> fast_sel_out == sel2_reg)
    else $error("wrong set in use");
  AST_CAP: assert property ($stable(limit_pct_out)[*4] ##0 (at_target_out &&
    !speed_rev_out) |-> speed_pct_out <= limit_pct_out) else $error("above limit");
  cover property ($fell(at_target_out));
  cover property ($rose(speed_rev_out));
  cover property (at_target_out && limit_pct_out < FULL_PCT);
endmodule
bind speed_limit_ramp_select speed_shape_asserts #(.STEP_CYCLES(STEP_CYCLES))
  speed_shape_asserts_inst (.clk_in, .resetn_in, .selector_present_in, .selector_fast_in,
  .demand_rev_in, .speed_rev_out, .speed_pct_out, .limit_pct_out, .fast_sel_out,
  .at_target_out);

// ### sim/throttle_model.sv
// Operator throttle holding the demand seen by the controller
`timescale 1ns/1ns
module throttle_model (
  // Clock and bench requests
  input  wire logic                  clk_in,
  input  wire logic                  rev_req_in,
  input  wire speed_shape_pkg::pct_t pct_req_in,
  // Demand to the controller
  output logic                       demand_rev_out,
  output speed_shape_pkg::pct_t      demand_pct_out
);
  import speed_shape_pkg::*;
  // Wiper lags one clock, as a filtered input would
  always @(posedge clk_in) begin
    demand_rev_out <= rev_req_in;
    demand_pct_out <= pct_req_in;
  end
endmodule

// ### sim/tb.sv
// Self-checking bench for the speed shaping top
`timescale 1ns/1ns
module tb;
  import speed_shape_pkg::*;
  localparam int STEP = 4;
  logic  clk_in = 1'b0;
  logic  resetn_in = 1'b0;
  ramp_t ramp [8];
  pct_t  mx_f, mx_s, mn_f, mn_s, dem, d_pct, spd, lim_o;
  logic  present, fast, pen, pval, dem_rev, d_rev, srev, fsel, atg;
  pot_t  pos;
  int    errors = 0;
  int    checks = 0;
  always #25 clk_in = ~clk_in;
  throttle_model throttle_model_inst (.clk_in, .rev_req_in(dem_rev), .pct_req_in(dem),
    .demand_rev_out(d_rev), .demand_pct_out(d_pct));
  speed_limit_ramp_select #(.STEP_CYCLES(STEP)) speed_limit_ramp_select_inst (.clk_in,
    .resetn_in, .fwd_accel_fast_in(ramp[0]), .fwd_accel_slow_in(ramp[1]),
    .fwd_decel_fast_in(ramp[2]), .fwd_decel_slow_in(ramp[3]), .rev_accel_fast_in(ramp[4]),
    .rev_accel_slow_in(ramp[5]), .rev_decel_fast_in(ramp[6]), .rev_decel_slow_in(ramp[7]),
    .max_fwd_fast_in(mx_f), .max_fwd_slow_in(mx_s), .min_fwd_fast_in(mn_f),
    .min_fwd_slow_in(mn_s), .selector_present_in(present), .selector_fast_in(fast),
    .pot_enable_in(pen), .pot_valid_in(pval), .pot_position_in(pos),
    .demand_rev_in(d_rev), .demand_pct_in(d_pct), .speed_rev_out(srev),
    .speed_pct_out(spd), .limit_pct_out(lim_o), .fast_sel_out(fsel), .at_target_out(atg));
  function automatic int exp_lim();
    int mx, mn;
    mx = (!present || fast) ? mx_f : mx_s;
    mn = (!present || fast) ? mn_f : mn_s;
    if (mx > 100) mx = 100;
    if (mn > mx) mn = mx;
    if (!pen) return mx;
    if (!pval) return mn;
    return mn + (((mx - mn) * (pos + pos[7])) >> 8);
  endfunction
  function automatic int exp_spd(logic r, int p);
    int c;
    c = r ? 100 : exp_lim();
    return p > c ? c : p;
  endfunction
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Sampled on the falling edge, clear of the launch edge
  task automatic settle(output int n);
    n = 6;
    repeat (6) @(negedge clk_in);
    while (atg !== 1'b1) begin
      @(negedge clk_in);
      n++;
      if (n > 5000) begin
        errors++;
        final_report();
      end
    end
  endtask
  initial begin
    int n, t, d, e, prev;
    logic pr;
    foreach (ramp[k]) ramp[k] = RAMP_ZERO;
    {mx_f, mx_s, mn_f, mn_s, dem, pos} = '0;
    {present, fast, pen, pval, dem_rev} = '0;
    void'($urandom(32'h94c5c2d0));
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      @(posedge clk_in);
      foreach (ramp[k]) ramp[k] <= 8'($urandom_range(3));
      mx_f <= 7'($urandom);
      mx_s <= 7'($urandom);
      mn_f <= (i == 2) ? 7'h7f : 7'($urandom);
      mn_s <= (i == 2) ? 7'h7f : 7'($urandom);
      {present, fast, pen, pval} <= (i < 3) ? {2'($urandom), 2'h3} : 4'($urandom);
      pos <= (i == 1) ? 8'hff : (i < 3) ? 8'h00 : 8'($urandom);
      settle(n);
      check(lim_o, 8'(exp_lim()));
      check(fsel, !present || fast);
      check(spd, 8'(exp_spd(dem_rev, dem)));
      prev = exp_spd(dem_rev, dem);
      pr = dem_rev;
      @(posedge clk_in);
      dem_rev <= (i == 7) ? !dem_rev : (i > 5) ? 1'($urandom) : 1'b0;
      dem <= (i == 7) ? 7'h00 : 7'($urandom);
      settle(n);
      e = exp_spd(dem_rev, dem);
      check(spd, 8'(e));
      check(srev, dem_rev);
      if (pr == dem_rev && e != prev) begin
        t = (ramp[{dem_rev, e < prev, present & ~fast}] + 1) * STEP;
        d = e > prev ? e - prev : prev - e;
        check(n >= (d - 1) * t && n <= (d + 1) * t + 8, 8'h1);
      end
    end
    final_report();
  end
endmodule
